// ---- dec1_regs.sv ----
// Register bank and sync tracking of the first data decoder channel
`timescale 1ns/100ps
`default_nettype none
module dec1_regs
    import dec1_regs_pkg::*;
#(
    parameter logic [2:0] E_BLOCK_ID = 3'h4
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Decoder core side, same clock
    input wire logic blk_valid,
    input wire logic [2:0] blk_id,
    input wire logic [1:0] blk_raw_err,
    input wire logic [15:0] blk_word,
    input wire logic decoder_reset_event,
    input wire logic ch1_bit_clock,
    input wire logic ch2_data_available_n,
    // Pin and decoder settings
    output logic shared_clock_avail_pin,
    output logic [1:0] io_mode,
    output logic [1:0] ch1_decoder_mode,
    output logic ch1_restart_sync,
    output logic [1:0] ch1_burst_correction,
    output logic ch1_e_block_accept,
    output logic ch1_sync_found
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ctrl_t ctrl;
        set_t set;
        logic [5:0] bad_cnt;
        logic [5:0] good_cnt;
        sync_state_t sync;
        logic unread;
        logic ovf;
        logic rstd;
        logic restart;
        logic pin_out;
        logic dp_valid;
        logic dp_write;
        logic [29:0] dp_idx;
        logic ready;
        logic resp;
        logic [31:0] rdata;
    } regs_t;

    regs_t st_ff;
    regs_t nxt_st;
    blk_t last_blk;
    blk_t prev_blk;
    blk_t cap_blk;
    logic capture;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Error status after correction with the selected burst strength
    function automatic logic [1:0] classify(input logic [1:0] raw,
                                            input logic [1:0] burst);
        logic [1:0] res;
        res = ERR_UNCORR;
        if (raw == ERR_NONE) begin
            res = ERR_NONE;
        end else if (burst == BURST_2 && raw == ERR_FIX2) begin
            res = ERR_FIX2;
        end else if (burst == BURST_5 && raw != ERR_UNCORR) begin
            res = raw;
        end
        return res;
    endfunction : classify

    // Saturating six-bit increment
    function automatic logic [5:0] inc6(input logic [5:0] v);
        return (v == 6'h3F) ? v : 6'(v + 6'h01);
    endfunction : inc6

    // Read multiplexer over the register map
    function automatic logic [15:0] read_word(input logic [29:0] idx,
                                              input regs_t s,
                                              input blk_t lb,
                                              input blk_t pb);
        logic [15:0] w;
        logic [15:0] c;
        w = 16'h0000;
        c = s.ctrl;
        unique case (idx)
            IDX_DECODER1_STATUS: begin
                w[STAT_SYNC_BIT] = (s.sync == SYNC_LOCKED);
                w[STAT_OVF_BIT] = s.ovf;
                w[STAT_RSTD_BIT] = s.rstd;
                w[STAT_ID_LSB +: 3] = lb.id;
                w[STAT_ERR_LSB +: 2] = lb.err;
            end
            IDX_DECODER1_LAST_BLOCK_DATA: w = lb.word;
            IDX_DECODER1_PREV_BLOCK_DATA: w = pb.word;
            IDX_DECODER1_BLOCK_COUNTERS: begin
                w[CNT_BAD_LSB +: 6] = s.bad_cnt;
                w[CNT_GOOD_LSB +: 5] = s.good_cnt[5:1];
                w[CNT_ID_LSB +: 3] = pb.id;
                w[CNT_ERR_LSB +: 2] = pb.err;
            end
            IDX_DECODER1_SETTINGS: begin
                w = s.set;
                w[15] = 1'b0;
            end
            IDX_DECODER1_CONTROL: begin
                w = c;
                w[15:11] = 5'h00;
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_t wc;
        set_t ws;
        logic take;
        logic restart_req;
        logic good;
        logic bad;
        logic e_reject;
        logic ovf_set;
        logic rd_status;
        logic rd_last;
        logic [29:0] aidx;
        wc = ctrl_t'(hwdata[15:0]);
        ws = set_t'(hwdata[15:0]);
        take = 1'b0;
        restart_req = 1'b0;
        good = 1'b0;
        bad = 1'b0;
        e_reject = 1'b0;
        ovf_set = 1'b0;
        rd_status = 1'b0;
        rd_last = 1'b0;
        aidx = haddr[31:2];
        cap_blk = '{blk_id, BLK_ERR_RESET, blk_word};
        capture = 1'b0;
        nxt_st = st_ff;
        nxt_st.restart = 1'b0;
        nxt_st.ready = 1'b1;
        nxt_st.resp = 1'b0;

        // Shared pin role
        nxt_st.pin_out = st_ff.ctrl.shared_pin_role_select ?
                         ch2_data_available_n : ch1_bit_clock;

        // Write data phase
        if (st_ff.dp_valid && st_ff.dp_write) begin
            unique case (st_ff.dp_idx)
                IDX_DECODER1_CONTROL: begin
                    nxt_st.ctrl.shared_pin_role_select =
                        wc.shared_pin_role_select;
                    if (wc.io_mode != IO_FORBIDDEN) begin
                        nxt_st.ctrl.io_mode = wc.io_mode;
                    end
                    nxt_st.ctrl.ch1_decoder_mode = wc.ch1_decoder_mode;
                    nxt_st.ctrl.ch1_bad_gain_threshold =
                        wc.ch1_bad_gain_threshold;
                    restart_req = wc.ch1_restart_sync;
                end
                IDX_DECODER1_SETTINGS: begin
                    nxt_st.set = ws;
                    nxt_st.set.unused = 1'b0;
                end
                default: ;
            endcase
        end
        nxt_st.ctrl.ch1_restart_sync = 1'b0;
        nxt_st.ctrl.unused = 5'h00;
        nxt_st.restart = restart_req;

        // Block acceptance and error classification
        if (blk_valid) begin
            e_reject = (blk_id == E_BLOCK_ID) &&
                       !st_ff.set.ch1_e_block_accept;
            if (st_ff.ctrl.ch1_decoder_mode == MODE_BYPASS) begin
                cap_blk.err = blk_raw_err;
            end else begin
                cap_blk.err = classify(blk_raw_err,
                                       st_ff.set.ch1_burst_correction);
            end
            good = !e_reject && (cap_blk.err != ERR_UNCORR);
            bad = !good;
            capture = !e_reject;
            if (st_ff.ctrl.ch1_decoder_mode == MODE_REDUCED && bad) begin
                capture = 1'b0;
            end
            if (st_ff.ctrl.ch1_decoder_mode == MODE_BYPASS) begin
                good = 1'b0;
                bad = 1'b0;
            end
        end

        // Sync search and loss
        if (restart_req) begin
            nxt_st.sync = SYNC_SEARCH;
            nxt_st.bad_cnt = 6'h00;
            nxt_st.good_cnt = 6'h00;
        end else begin
            unique case (st_ff.sync)
                SYNC_SEARCH: begin
                    if (good) begin
                        nxt_st.sync = SYNC_LOCKED;
                        nxt_st.good_cnt = 6'h01;
                        nxt_st.bad_cnt = 6'h00;
                    end else if (bad) begin
                        nxt_st.bad_cnt = inc6(st_ff.bad_cnt);
                        if (st_ff.bad_cnt >=
                            {1'b0, st_ff.ctrl.ch1_bad_gain_threshold}) begin
                            nxt_st.bad_cnt = 6'h00;
                            nxt_st.good_cnt = 6'h00;
                        end
                    end
                end
                SYNC_LOCKED: begin
                    if (good) begin
                        nxt_st.good_cnt = inc6(st_ff.good_cnt);
                        if (inc6(st_ff.good_cnt) >=
                            st_ff.set.ch1_good_lose_threshold) begin
                            nxt_st.good_cnt = 6'h00;
                            nxt_st.bad_cnt = 6'h00;
                        end
                    end else if (bad) begin
                        nxt_st.bad_cnt = inc6(st_ff.bad_cnt);
                        if (inc6(st_ff.bad_cnt) >=
                            st_ff.set.ch1_bad_lose_threshold) begin
                            nxt_st.sync = SYNC_SEARCH;
                            nxt_st.bad_cnt = 6'h00;
                            nxt_st.good_cnt = 6'h00;
                        end
                    end
                end
                default: begin
                    nxt_st.sync = SYNC_SEARCH;
                end
            endcase
        end

        // Address phase
        take = hsel && htrans[1] && hready;
        nxt_st.dp_valid = take;
        nxt_st.dp_write = take && hwrite;
        nxt_st.dp_idx = aidx;
        if (take && !hwrite) begin
            nxt_st.rdata = {16'h0000,
                            read_word(aidx, nxt_st, last_blk, prev_blk)};
            rd_status = (aidx == IDX_DECODER1_STATUS);
            rd_last = (aidx == IDX_DECODER1_LAST_BLOCK_DATA);
        end

        // Sticky flags; a set in the same cycle wins over the read clear
        ovf_set = capture && st_ff.unread && !rd_last;
        if (rd_last) begin
            nxt_st.unread = 1'b0;
        end
        if (capture) begin
            nxt_st.unread = 1'b1;
        end
        if (rd_status) begin
            nxt_st.ovf = 1'b0;
            nxt_st.rstd = 1'b0;
        end
        if (ovf_set) begin
            nxt_st.ovf = 1'b1;
        end
        if (decoder_reset_event) begin
            nxt_st.rstd = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.ctrl <= ctrl_t'(CTRL_RESET);
            st_ff.set <= set_t'(SET_RESET);
            st_ff.bad_cnt <= 6'h00;
            st_ff.good_cnt <= 6'h00;
            st_ff.sync <= SYNC_SEARCH;
            st_ff.unread <= 1'b0;
            st_ff.ovf <= 1'b0;
            st_ff.rstd <= 1'b0;
            st_ff.restart <= 1'b0;
            st_ff.pin_out <= 1'b0;
            st_ff.dp_valid <= 1'b0;
            st_ff.dp_write <= 1'b0;
            st_ff.dp_idx <= 30'h0000_0000;
            st_ff.ready <= 1'b1;
            st_ff.resp <= 1'b0;
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Block history
    // ------------------------------------------------------------------
    dec1_block_history u_history (
        .hclk(hclk),
        .hresetn(hresetn),
        .capture(capture),
        .blk_in(cap_blk),
        .last_blk(last_blk),
        .prev_blk(prev_blk)
    );

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign hreadyout = st_ff.ready;
    assign hresp = st_ff.resp;
    assign hrdata = st_ff.rdata;
    assign shared_clock_avail_pin = st_ff.pin_out;
    assign io_mode = st_ff.ctrl.io_mode;
    assign ch1_decoder_mode = st_ff.ctrl.ch1_decoder_mode;
    assign ch1_restart_sync = st_ff.restart;
    assign ch1_burst_correction = st_ff.set.ch1_burst_correction;
    assign ch1_e_block_accept = st_ff.set.ch1_e_block_accept;
    assign ch1_sync_found = (st_ff.sync == SYNC_LOCKED);

endmodule : dec1_regs
`default_nettype wire

// ---- dec1_regs_pkg.sv ----
// Shared constants and types for the first data decoder channel register set
package dec1_regs_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is index times four
    // ------------------------------------------------------------------
    localparam logic [29:0] IDX_DECODER1_STATUS = 30'h0000_6000;
    localparam logic [29:0] IDX_DECODER1_LAST_BLOCK_DATA = 30'h0000_6001;
    localparam logic [29:0] IDX_DECODER1_PREV_BLOCK_DATA = 30'h0000_6002;
    localparam logic [29:0] IDX_DECODER1_BLOCK_COUNTERS = 30'h0000_6003;
    localparam logic [29:0] IDX_DECODER1_SETTINGS = 30'h0000_6004;
    localparam logic [29:0] IDX_DECODER1_CONTROL = 30'h0000_6005;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0100;
    localparam logic [15:0] SET_RESET = 16'h1020;
    localparam logic [2:0] BLK_ID_RESET = 3'h7;
    localparam logic [1:0] BLK_ERR_RESET = 2'h0;
    localparam logic [15:0] BLK_WORD_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions of the status and counter words
    // ------------------------------------------------------------------
    localparam int STAT_SYNC_BIT = 7;
    localparam int STAT_OVF_BIT = 6;
    localparam int STAT_RSTD_BIT = 5;
    localparam int STAT_ID_LSB = 2;
    localparam int STAT_ERR_LSB = 0;
    localparam int CNT_BAD_LSB = 10;
    localparam int CNT_GOOD_LSB = 5;
    localparam int CNT_ID_LSB = 2;
    localparam int CNT_ERR_LSB = 0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] IO_DECODER = 2'h0;
    localparam logic [1:0] IO_BURST_EXT_CLK = 2'h1;
    localparam logic [1:0] IO_DEMODULATOR = 2'h2;
    localparam logic [1:0] IO_FORBIDDEN = 2'h3;
    localparam logic [1:0] MODE_STANDARD = 2'h0;
    localparam logic [1:0] MODE_FAST_PI = 2'h1;
    localparam logic [1:0] MODE_REDUCED = 2'h2;
    localparam logic [1:0] MODE_BYPASS = 2'h3;
    localparam logic [1:0] BURST_OFF_A = 2'h0;
    localparam logic [1:0] BURST_2 = 2'h1;
    localparam logic [1:0] BURST_5 = 2'h2;
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_FIX2 = 2'h1;
    localparam logic [1:0] ERR_FIX5 = 2'h2;
    localparam logic [1:0] ERR_UNCORR = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] unused;
        logic shared_pin_role_select;
        logic [1:0] io_mode;
        logic [1:0] ch1_decoder_mode;
        logic ch1_restart_sync;
        logic [4:0] ch1_bad_gain_threshold;
    } ctrl_t;

    typedef struct packed {
        logic unused;
        logic [1:0] ch1_burst_correction;
        logic [5:0] ch1_good_lose_threshold;
        logic ch1_e_block_accept;
        logic [5:0] ch1_bad_lose_threshold;
    } set_t;

    typedef struct packed {
        logic [2:0] id;
        logic [1:0] err;
        logic [15:0] word;
    } blk_t;

    typedef enum logic [1:0] {
        SYNC_SEARCH = 2'b01,
        SYNC_LOCKED = 2'b10
    } sync_state_t;

endpackage : dec1_regs_pkg

// ---- dec1_block_history.sv ----
// Last and previous block holding registers of the decoder channel
`timescale 1ns/100ps
`default_nettype none
module dec1_block_history
    import dec1_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic capture,
    input wire blk_t blk_in,
    output blk_t last_blk,
    output blk_t prev_blk
);

    typedef struct packed {
        blk_t last;
        blk_t prev;
    } hist_t;

    hist_t st_ff;
    hist_t nxt_st;

    // ------------------------------------------------------------------
    // Shift on every accepted block
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (capture) begin
            nxt_st.prev = st_ff.last;
            nxt_st.last = blk_in;
        end
    end

    // Registered copy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{last: '{BLK_ID_RESET, BLK_ERR_RESET, BLK_WORD_RESET},
                       prev: '{BLK_ID_RESET, BLK_ERR_RESET, BLK_WORD_RESET}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign last_blk = st_ff.last;
    assign prev_blk = st_ff.prev;

endmodule : dec1_block_history
`default_nettype wire

// ---- dec1_regs_props.sv ----
// Assertion checker for the decoder channel register bank
`timescale 1ns/100ps
`default_nettype none
module dec1_regs_props
    import dec1_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic ch1_bit_clock,
    input wire logic ch2_data_available_n,
    input wire logic shared_clock_avail_pin,
    input wire logic [1:0] io_mode,
    input wire logic [1:0] ch1_decoder_mode,
    input wire logic ch1_restart_sync,
    input wire logic [1:0] ch1_burst_correction,
    input wire logic ch1_e_block_accept,
    input wire logic ch1_sync_found
);
    // ------
    // Data phase tracking
    // ------
    logic take;
    logic wc_ff, ws_ff, rs_ff, sel_ff, up_ff;
    assign take = hsel && htrans[1] && hready;
    // Marks data phases and mirrors the pin role bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wc_ff <= 1'b0;
            ws_ff <= 1'b0;
            rs_ff <= 1'b0;
            sel_ff <= 1'b0;
            up_ff <= 1'b0;
        end else begin
            wc_ff <= take && hwrite && haddr[31:2] == IDX_DECODER1_CONTROL;
            ws_ff <= take && hwrite && haddr[31:2] == IDX_DECODER1_SETTINGS;
            rs_ff <= take && !hwrite && haddr[31:2] == IDX_DECODER1_STATUS;
            up_ff <= 1'b1;
            if (wc_ff) begin
                sel_ff <= hwdata[10];
            end
        end
    end
    // ------
    // Properties
    // ------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence ctrl_wr_s;
        wc_ff && hwdata[9:8] != IO_FORBIDDEN;
    endsequence
    sequence restart_wr_s;
        wc_ff && hwdata[5];
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    io_mode_wr_a: assert property (ctrl_wr_s |=>
        io_mode == $past(hwdata[9:8])) else $error("io mode not written");
    io_forbid_a: assert property (wc_ff && hwdata[9:8] == IO_FORBIDDEN
        |=> $stable(io_mode)) else $error("forbidden io mode taken");
    dec_mode_wr_a: assert property (wc_ff |=>
        ch1_decoder_mode == $past(hwdata[7:6])) else $error("mode not written");
    restart_pulse_a: assert property (restart_wr_s |=>
        ch1_restart_sync) else $error("restart pulse missing");
    restart_cause_a: assert property (ch1_restart_sync |->
        $past(wc_ff && hwdata[5])) else $error("restart without write");
    burst_wr_a: assert property (ws_ff |=>
        ch1_burst_correction == $past(hwdata[14:13])
        && ch1_e_block_accept == $past(hwdata[6])) else $error("settings out");
    pin_route_a: assert property (up_ff |-> shared_clock_avail_pin ==
        $past(sel_ff ? ch2_data_available_n : ch1_bit_clock))
        else $error("shared pin wrong source");
    sync_read_a: assert property (rs_ff |->
        hrdata[7] == ch1_sync_found && hrdata[31:16] == 16'h0000)
        else $error("status read mismatch");
endmodule : dec1_regs_props
bind dec1_regs dec1_regs_props dec1_regs_props_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .ch1_bit_clock, .ch2_data_available_n, .shared_clock_avail_pin,
    .io_mode, .ch1_decoder_mode, .ch1_restart_sync, .ch1_burst_correction,
    .ch1_e_block_accept, .ch1_sync_found);
`default_nettype wire

// ---- dec1_host_model.sv ----
// Bus master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module dec1_host_model (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Bus idle from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One single word transfer, waits on ready in both phases
    task automatic xfer(input logic wr, input logic [29:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
endmodule : dec1_host_model
`default_nettype wire

// ---- test_rds_channel1_decoder_regs.sv ----
// Self-checking bench for the decoder channel register bank
`timescale 1ns/100ps
`default_nettype none
module test_rds_channel1_decoder_regs;
    import dec1_regs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, blk_valid;
    logic decoder_reset_event, ch1_bit_clock, ch2_data_available_n;
    logic shared_clock_avail_pin, ch1_restart_sync, ch1_e_block_accept;
    logic ch1_sync_found;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, blk_raw_err, io_mode, ch1_decoder_mode;
    logic [1:0] ch1_burst_correction;
    logic [2:0] hsize, blk_id;
    logic [15:0] blk_word;
    int errors, tests_run, cycles;
    dec1_regs #(.E_BLOCK_ID(3'h4)) dec1_regs_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .blk_valid, .blk_id, .blk_raw_err,
        .blk_word, .decoder_reset_event, .ch1_bit_clock,
        .ch2_data_available_n, .shared_clock_avail_pin, .io_mode,
        .ch1_decoder_mode, .ch1_restart_sync, .ch1_burst_correction,
        .ch1_e_block_accept, .ch1_sync_found);
    dec1_host_model dec1_host_model_inst (.hclk, .hreadyout, .hrdata, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata);
    // ------
    // Clock, bit clock source and timeout
    // ------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        ch1_bit_clock <= ~ch1_bit_clock;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
    // ------
    // Shared tasks
    // ------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic rdchk(input string name, input logic [29:0] idx,
                         input logic [31:0] exp);
        logic [31:0] v;
        dec1_host_model_inst.xfer(1'b0, idx, 32'h0, v);
        chk(name, v, exp);
    endtask : rdchk
    task automatic wr(input logic [29:0] idx, input logic [31:0] d);
        logic [31:0] v;
        dec1_host_model_inst.xfer(1'b1, idx, d, v);
    endtask : wr
    task automatic blk(input logic [2:0] id, input logic [1:0] e,
                       input logic [15:0] w);
        blk_valid <= 1'b1;
        blk_id <= id;
        blk_raw_err <= e;
        blk_word <= w;
        @(posedge hclk);
        blk_valid <= 1'b0;
    endtask : blk
    task automatic complete_run();
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // ------
    // Scenarios
    // ------
    task automatic t_reset();
        rdchk("status", IDX_DECODER1_STATUS, 32'h001C);
        rdchk("last", IDX_DECODER1_LAST_BLOCK_DATA, 32'h0);
        rdchk("prev", IDX_DECODER1_PREV_BLOCK_DATA, 32'h0);
        rdchk("counters", IDX_DECODER1_BLOCK_COUNTERS, 32'h001C);
        rdchk("settings", IDX_DECODER1_SETTINGS, 32'h1020);
        rdchk("control", IDX_DECODER1_CONTROL, 32'h0100);
        rdchk("unmapped", IDX_DECODER1_CONTROL + 30'h1, 32'h0);
        chk("io_mode", {30'h0, io_mode}, {30'h0, IO_BURST_EXT_CLK});
    endtask : t_reset
    task automatic t_ctrl();
        logic [1:0] c;
        logic [1:0] io;
        io = IO_BURST_EXT_CLK;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            io = (c == IO_FORBIDDEN) ? io : c;
            wr(IDX_DECODER1_CONTROL, {16'hFFFF, 5'h1F, c[0], c, c, 6'h35});
            rdchk("control", IDX_DECODER1_CONTROL,
                {21'h0, c[0], io, c, 6'h15});
            chk("io_mode", {30'h0, io_mode}, {30'h0, io});
            chk("mode", {30'h0, ch1_decoder_mode}, {30'h0, c});
        end
        chk("pin", {31'h0, shared_clock_avail_pin}, 32'h1);
        wr(IDX_DECODER1_CONTROL, 32'h0);
        rdchk("control", IDX_DECODER1_CONTROL, 32'h0);
        chk("pin", {31'h0, shared_clock_avail_pin},
            {31'h0, ~ch1_bit_clock});
    endtask : t_ctrl
    task automatic t_set();
        logic [31:0] s;
        s = {16'h0, 1'b0, BURST_2, 6'h3F, 1'b0, 6'h02};
        wr(IDX_DECODER1_SETTINGS, 32'hFFFF_FFFF);
        rdchk("settings", IDX_DECODER1_SETTINGS, 32'h7FFF);
        chk("burst", {30'h0, ch1_burst_correction}, 32'h3);
        chk("e_accept", {31'h0, ch1_e_block_accept}, 32'h1);
        wr(IDX_DECODER1_SETTINGS, s);
        rdchk("settings", IDX_DECODER1_SETTINGS, s);
        chk("e_accept", {31'h0, ch1_e_block_accept}, 32'h0);
    endtask : t_set
    task automatic t_blocks();
        blk(3'h0, ERR_NONE, 16'hA1A1);
        rdchk("last", IDX_DECODER1_LAST_BLOCK_DATA, 32'hA1A1);
        blk(3'h1, 2'h1, 16'hB2B2);
        rdchk("status", IDX_DECODER1_STATUS, 32'h0085);
        chk("sync", {31'h0, ch1_sync_found}, 32'h1);
        rdchk("prev", IDX_DECODER1_PREV_BLOCK_DATA, 32'hA1A1);
        rdchk("counters", IDX_DECODER1_BLOCK_COUNTERS, 32'h0020);
        blk(3'h2, 2'h2, 16'hC3C3);
        rdchk("status", IDX_DECODER1_STATUS, 32'h00CB);
        rdchk("status", IDX_DECODER1_STATUS, 32'h008B);
        rdchk("counters", IDX_DECODER1_BLOCK_COUNTERS, 32'h0425);
        rdchk("last", IDX_DECODER1_LAST_BLOCK_DATA, 32'hC3C3);
        // Rejected E block pushes bad count to the lose threshold
        blk(3'h4, ERR_NONE, 16'hD4D4);
        decoder_reset_event <= 1'b1;
        @(posedge hclk);
        decoder_reset_event <= 1'b0;
        rdchk("status", IDX_DECODER1_STATUS, 32'h002B);
        rdchk("status", IDX_DECODER1_STATUS, 32'h000B);
        chk("sync", {31'h0, ch1_sync_found}, 32'h0);
        rdchk("counters", IDX_DECODER1_BLOCK_COUNTERS, 32'h0005);
        // Bypass passes the raw error and freezes the counts
        wr(IDX_DECODER1_CONTROL, 32'h00C0);
        blk(3'h3, 2'h2, 16'hE5E5);
        rdchk("status", IDX_DECODER1_STATUS, 32'h000E);
        // Reduced mode drops uncorrectable data; gain threshold of five
        wr(IDX_DECODER1_CONTROL, 32'h0085);
        blk(3'h5, 2'h3, 16'hF6F6);
        rdchk("counters", IDX_DECODER1_BLOCK_COUNTERS, 32'h040B);
    endtask : t_blocks
    // Main sequence
    initial begin
        hresetn = 1'b0;
        blk_valid = 1'b0;
        blk_id = 3'h0;
        blk_raw_err = 2'h0;
        blk_word = 16'h0;
        decoder_reset_event = 1'b0;
        ch1_bit_clock = 1'b0;
        ch2_data_available_n = 1'b1;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_ctrl();
        t_set();
        t_blocks();
        complete_run();
    end
endmodule : test_rds_channel1_decoder_regs
`default_nettype wire
